// ---- design/abs_position_calc.v ----
/*
 * Combines turn count and single-turn position into a signed 64-bit position.
 * Assumes encoder inputs are stable in the cycle they are sampled.
 */
`include "position_gear_defs.vh"

module abs_position_calc (
	input  wire [15:0] i_turn,
	input  wire [31:0] i_single,
	output wire [63:0] o_pos
);

	wire signed [63:0] turns_signed;
	wire [63:0]        single_masked;

	// Values at or above half wrap are negative turns
	assign turns_signed = (i_turn < `TURN_HALF) ? {48'h000000000000, i_turn}
	                      : ({48'h000000000000, i_turn} - {47'h000000000000, `TURN_WRAP});
	assign single_masked = {32'h00000000, i_single & ((32'h00000001 << `RES_BITS) - 32'h00000001)};
	// 64-bit shift by resolution cannot overflow for 16-bit turns
	assign o_pos = (turns_signed <<< `RES_BITS) + single_masked;

endmodule // abs_position_calc

// ---- design/gear_scale.v ----
/*
 * Scales command units to encoder units by numerator over denominator.
 * Assumes a zero denominator yields zero rather than a fault.
 */
`include "position_gear_defs.vh"

module gear_scale (
	input  wire [31:0] i_cmd,
	input  wire [31:0] i_num,
	input  wire [31:0] i_den,
	output wire [31:0] o_enc
);

	wire [63:0] product;
	wire [63:0] quotient;

	// Combinational divide: large; full 64-bit product, quotient truncated to 32 bits
	assign product  = {32'h00000000, i_cmd} * {32'h00000000, i_num};
	assign quotient = (i_den == `DEAD_WORD) ? 64'h0000000000000000 : product / {32'h00000000, i_den};
	assign o_enc    = quotient[31:0];

endmodule // gear_scale

// ---- design/position_gear_defs.vh ----
/*
 * Constants for the absolute position, gear and fault stop block.
 * Assumes a 20 MHz clock and an Avalon-MM slave with 32-bit words.
 */
// How it works
// - Single-turn position below encoder resolution
// - Turn count below 32768 counts positive
// - Turn count 32768 or more subtracts 65536
// - Position split into high and low words
// - First battery connect raises fault; host resets
// - Battery below 3.0 V raises warning
// - Encoder units equal command times num/den
// - Control values are command units before gearing
// - Gear registers default one, apply when stopped
// - Brake disabled ignores brake output delay
// - Class-one fault cuts power, coasts freely
// - Class-two without brake or zero stop, DB stop held
// - Braked stop cuts power on delay or speed
`ifndef POSITION_GEAR_DEFS_VH
`define POSITION_GEAR_DEFS_VH

`define RES_BITS        5'd23
`define TURN_HALF       16'h8000
`define TURN_WRAP       17'h10000
`define BATT_LOW_MV     16'h0BB8

`define ADDR_GEAR_NUM   4'h0
`define ADDR_GEAR_DEN   4'h1
`define ADDR_CMD_IN     4'h2
`define ADDR_CMD_OUT    4'h3
`define ADDR_POS_LO     4'h4
`define ADDR_POS_HI     4'h5
`define ADDR_TURN       4'h6
`define ADDR_SINGLE     4'h7
`define ADDR_FLT_RESET  4'h8
`define ADDR_STOP_CFG   4'h9
`define ADDR_STATUS     4'hA
`define ADDR_MASK       4'hB
`define ADDR_IRQ_STAT   4'hC
`define ADDR_OFF_DELAY  4'hD
`define ADDR_OFF_SPEED  4'hE
`define ADDR_BRK_DELAY  4'hF

`define GEAR_RESET      32'h00000001
`define FLT_RESET_VAL   32'h00000001
`define DEAD_WORD       32'h00000000

`define IRQ_BATT_FAULT  0
`define IRQ_BATT_WARN   1
`define IRQ_FAULT1      2
`define IRQ_FAULT2      3
`define IRQ_STOPPED     4
`define IRQ_W           5

`define CFG_BRAKE_EN    0
`define CFG_HAS_BRAKE   1
`define CFG_ZERO_STOP   2

`endif

// ---- design/position_gear_stop.v ----
/*
 * Absolute position feedback, electronic gear and fault stop sequencing.
 * Assumes Avalon-MM master on word addresses and an encoder on plain inputs.
 */
// The Avalon-MM slave port and the register offsets were decided locally.
`include "position_gear_defs.vh"

module position_gear_stop (
	input  wire        i_clk,
	input  wire        i_nrst,
	input  wire [3:0]  i_address,
	input  wire        i_read,
	input  wire        i_write,
	input  wire [31:0] i_writedata,
	input  wire [3:0]  i_byteenable,
	output reg  [31:0] o_readdata,
	output reg         o_waitrequest,
	output reg  [1:0]  o_response,
	input  wire [15:0] i_encoder_turn_count,
	input  wire [31:0] i_single_turn_position,
	input  wire        i_battery_first_connect,
	input  wire [15:0] i_battery_mv,
	input  wire        i_fault_class1,
	input  wire        i_fault_class2,
	input  wire        i_motor_stopped,
	input  wire [31:0] i_motor_speed,
	input  wire        i_power_on_seq,
	output reg         o_motor_power,
	output reg         o_dynamic_braking,
	output reg         o_zero_speed_stop,
	output reg         o_brake_release,
	output reg         o_servo_alarm,
	output reg         o_battery_fault,
	output reg         o_battery_warning,
	output reg         o_irq
);

	localparam ST_RUN   = 3'd0;
	localparam ST_FREE  = 3'd1;
	localparam ST_DB    = 3'd2;
	localparam ST_ZERO  = 3'd3;
	localparam ST_BRAKE = 3'd4;

	reg  [31:0] gear_numerator;
	reg  [31:0] gear_denominator;
	reg  [31:0] pend_num;
	reg  [31:0] pend_den;
	reg  [31:0] cmd_in;
	reg  [31:0] cmd_out;
	reg  [2:0]  stop_cfg;
	reg  [31:0] power_off_delay;
	reg  [31:0] power_off_speed_threshold;
	reg  [31:0] brake_output_delay;
	reg  [31:0] delay_cnt;
	reg  [31:0] brake_cnt;
	reg  [`IRQ_W-1:0] irq_stat;
	reg  [`IRQ_W-1:0] irq_mask;
	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg         pend_gear;
	reg         fault_reset;
	reg         ack;
	reg  [31:0] next_rd;

	wire [63:0] abs_pos;
	wire [31:0] enc_units;
	wire        batt_low;
	wire [`IRQ_W-1:0] events;
	wire        wr_hit;
	wire        rd_hit;
	wire        req_new;
	wire        brake_done;

	abs_position_calc u_abs (
		.i_turn   (i_encoder_turn_count),
		.i_single (i_single_turn_position),
		.o_pos    (abs_pos)
	);

	// Control values arrive in command units and are geared here
	gear_scale u_gear (
		.i_cmd (cmd_in),
		.i_num (gear_numerator),
		.i_den (gear_denominator),
		.o_enc (enc_units)
	);

	// Byte lanes let software update part of a wide setting
	function [31:0] merge_bytes;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  be;
		integer k;
		begin
			merge_bytes = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k])
					merge_bytes[k*8 +: 8] = data[k*8 +: 8];
			end
		end
	endfunction

	assign batt_low = (i_battery_mv < `BATT_LOW_MV);
	assign wr_hit   = i_write && !ack;
	assign rd_hit   = i_read && !ack;
	assign req_new  = (i_read || i_write) && !ack;
	// Power-off of a braked stop: delay expiry or low speed, whichever first
	assign brake_done = (delay_cnt >= power_off_delay) || (i_motor_speed < power_off_speed_threshold);
	// Bit order follows the irq status layout
	assign events   = {state != ST_RUN && next_state == ST_RUN,
	                   i_fault_class2 && state == ST_RUN,
	                   i_fault_class1 && state != ST_FREE,
	                   batt_low && !o_battery_warning,
	                   i_battery_first_connect};

	// Fault stop sequencer
	always @* begin
		next_state = state;
		case (state)
		// Class-one takes priority over any class-two stop choice
		ST_RUN: begin
			if (i_fault_class1)
				next_state = ST_FREE;
			else if (i_fault_class2 && stop_cfg[`CFG_HAS_BRAKE])
				next_state = ST_BRAKE;
			else if (i_fault_class2 && stop_cfg[`CFG_ZERO_STOP])
				next_state = ST_ZERO;
			else if (i_fault_class2)
				next_state = ST_DB;
		end
		ST_ZERO: begin
			if (i_fault_class1)
				next_state = ST_FREE;
			else if (i_motor_stopped)
				next_state = ST_FREE;
		end
		ST_BRAKE: begin
			if (i_fault_class1 || brake_done)
				next_state = ST_FREE;
		end
		default: begin
			// A class-one fault turns a braking stop into a coast
			if (state == ST_DB && i_fault_class1)
				next_state = ST_FREE;
			else if (fault_reset && !i_fault_class1 && !i_fault_class2)
				next_state = ST_RUN;
		end
		endcase
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state             <= ST_RUN;
			delay_cnt         <= 32'h00000000;
			brake_cnt         <= 32'h00000000;
			o_motor_power     <= 1'b1;
			o_dynamic_braking <= 1'b0;
			o_zero_speed_stop <= 1'b0;
			o_brake_release   <= 1'b0;
			o_servo_alarm     <= 1'b0;
		end else begin
			state             <= next_state;
			delay_cnt         <= (next_state == ST_BRAKE && state == ST_BRAKE) ? delay_cnt + 32'h00000001
			                     : 32'h00000000;
			o_motor_power     <= (next_state == ST_RUN || next_state == ST_ZERO || next_state == ST_BRAKE);
			o_dynamic_braking <= (next_state == ST_DB);
			o_zero_speed_stop <= (next_state == ST_ZERO || next_state == ST_BRAKE);
			o_servo_alarm     <= (next_state != ST_RUN);
			// Brake release waits its delay only when the brake is enabled
			if (next_state != ST_RUN || !i_power_on_seq) begin
				brake_cnt       <= 32'h00000000;
				o_brake_release <= 1'b0;
			end else if (!stop_cfg[`CFG_BRAKE_EN] || brake_cnt >= brake_output_delay) begin
				o_brake_release <= 1'b1;
			end else begin
				brake_cnt <= brake_cnt + 32'h00000001;
			end
		end
	end

	// Gear pending values apply only while the drive is stopped
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gear_numerator   <= `GEAR_RESET;
			gear_denominator <= `GEAR_RESET;
			pend_num         <= `GEAR_RESET;
			pend_den         <= `GEAR_RESET;
			pend_gear        <= 1'b0;
			cmd_in           <= `DEAD_WORD;
			cmd_out          <= `DEAD_WORD;
			stop_cfg         <= 3'b000;
			power_off_delay  <= `DEAD_WORD;
			power_off_speed_threshold <= `DEAD_WORD;
			brake_output_delay <= `DEAD_WORD;
			irq_mask         <= {`IRQ_W{1'b0}};
			fault_reset      <= 1'b0;
		end else begin
			fault_reset <= 1'b0;
			cmd_out     <= enc_units;
			if (pend_gear && i_motor_stopped) begin
				gear_numerator   <= pend_num;
				gear_denominator <= pend_den;
				pend_gear        <= 1'b0;
			end
			if (wr_hit) begin
				if (i_address == `ADDR_GEAR_NUM) begin
					pend_num  <= merge_bytes(pend_num, i_writedata, i_byteenable);
					pend_gear <= 1'b1;
				end else if (i_address == `ADDR_GEAR_DEN) begin
					pend_den  <= merge_bytes(pend_den, i_writedata, i_byteenable);
					pend_gear <= 1'b1;
				end else if (i_address == `ADDR_CMD_IN)
					cmd_in <= merge_bytes(cmd_in, i_writedata, i_byteenable);
				else if (i_address == `ADDR_FLT_RESET)
					fault_reset <= (i_writedata == `FLT_RESET_VAL);
				else if (i_address == `ADDR_STOP_CFG)
					stop_cfg <= i_writedata[2:0];
				else if (i_address == `ADDR_MASK)
					irq_mask <= i_writedata[`IRQ_W-1:0];
				else if (i_address == `ADDR_OFF_DELAY)
					power_off_delay <= merge_bytes(power_off_delay, i_writedata, i_byteenable);
				else if (i_address == `ADDR_OFF_SPEED)
					power_off_speed_threshold <= merge_bytes(power_off_speed_threshold, i_writedata, i_byteenable);
				else if (i_address == `ADDR_BRK_DELAY)
					brake_output_delay <= merge_bytes(brake_output_delay, i_writedata, i_byteenable);
			end
		end
	end

	// Battery flags and sticky interrupt status; a new event beats the read clear
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_battery_fault   <= 1'b0;
			o_battery_warning <= 1'b0;
			irq_stat          <= {`IRQ_W{1'b0}};
			o_irq             <= 1'b0;
		end else begin
			if (i_battery_first_connect)
				o_battery_fault <= 1'b1;
			else if (fault_reset)
				o_battery_fault <= 1'b0;
			o_battery_warning <= batt_low;
			if (rd_hit && i_address == `ADDR_IRQ_STAT)
				irq_stat <= events;
			else
				irq_stat <= irq_stat | events;
			o_irq <= |((irq_stat | events) & irq_mask);
		end
	end

	// Read mux: unused indices read as zero
	always @* begin
		next_rd = `DEAD_WORD;
		if (i_address == `ADDR_GEAR_NUM)
			next_rd = gear_numerator;
		else if (i_address == `ADDR_GEAR_DEN)
			next_rd = gear_denominator;
		else if (i_address == `ADDR_CMD_IN)
			next_rd = cmd_in;
		else if (i_address == `ADDR_CMD_OUT)
			next_rd = cmd_out;
		else if (i_address == `ADDR_POS_LO)
			next_rd = abs_pos[31:0];
		else if (i_address == `ADDR_POS_HI)
			next_rd = abs_pos[63:32];
		else if (i_address == `ADDR_TURN)
			next_rd = {16'h0000, i_encoder_turn_count};
		else if (i_address == `ADDR_SINGLE)
			next_rd = i_single_turn_position & ((32'h00000001 << `RES_BITS) - 32'h00000001);
		else if (i_address == `ADDR_STOP_CFG)
			next_rd = {29'h00000000, stop_cfg};
		else if (i_address == `ADDR_STATUS)
			next_rd = {24'h000000, state, o_servo_alarm, o_motor_power, o_dynamic_braking,
			           o_battery_warning, o_battery_fault};
		else if (i_address == `ADDR_MASK)
			next_rd = {27'h0000000, irq_mask};
		else if (i_address == `ADDR_IRQ_STAT)
			next_rd = {27'h0000000, irq_stat};
		else if (i_address == `ADDR_OFF_DELAY)
			next_rd = power_off_delay;
		else if (i_address == `ADDR_OFF_SPEED)
			next_rd = power_off_speed_threshold;
		else if (i_address == `ADDR_BRK_DELAY)
			next_rd = brake_output_delay;
	end

	// One wait cycle per access; every address maps so response is always OK
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack           <= 1'b0;
			o_waitrequest <= 1'b1;
			o_readdata    <= `DEAD_WORD;
			o_response    <= 2'b00;
		end else begin
			ack           <= req_new;
			o_waitrequest <= !req_new;
			if (rd_hit)
				o_readdata <= next_rd;
		end
	end

endmodule // position_gear_stop

// ---- tb/motor_model.sv ----
/* Motor shaft on the far side of the stop logic.
   Assumes the bench asks for rotation and the block gives power and braking. */
module motor_model #(
	parameter logic [31:0] RUN_SPEED = 32'h00000010
) (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_run,
	input  wire logic        i_power,
	input  wire logic        i_brake_stop,
	output logic      [31:0] o_speed,
	output logic             o_stopped
);
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_speed <= 32'h0;
		else if (i_run && i_power && !i_brake_stop)
			o_speed <= RUN_SPEED;
		else if (o_speed != 32'h0)
			// Coasts down one step a cycle so no stop is instant
			o_speed <= o_speed - 32'h1;
	end
	assign o_stopped = (o_speed == 32'h0);
endmodule // motor_model

// ---- tb/pgs_asserts.sv ----
/* Port checker for position_gear_stop.
   Assumes it is bound into the design by the bench; one clock, async low reset. */
module pgs_asserts (
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic [3:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [15:0] i_battery_mv,
	input wire logic        i_battery_first_connect,
	input wire logic        i_fault_class1,
	input wire logic        i_motor_stopped,
	input wire logic        o_waitrequest,
	input wire logic [1:0]  o_response,
	input wire logic        o_motor_power,
	input wire logic        o_dynamic_braking,
	input wire logic        o_zero_speed_stop,
	input wire logic        o_servo_alarm,
	input wire logic        o_battery_fault,
	input wire logic        o_battery_warning
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	property p_ack_next;
		(i_read || i_write) && o_waitrequest |=> !o_waitrequest;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
	property p_ack_pulse;
		!o_waitrequest |=> o_waitrequest;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("waitrequest low too long");
	property p_resp_ok;
		o_response == 2'b00;
	endproperty
	a_resp_ok: assert property (p_resp_ok) else $error("response not okay");
	property p_alarm_set;
		i_fault_class1 |=> o_servo_alarm;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm missing on fault");
	property p_c1_off;
		i_fault_class1 |=> !o_motor_power && !o_dynamic_braking;
	endproperty
	a_c1_off: assert property (p_c1_off) else $error("power kept on class one fault");
	property p_alarm_hold;
		o_servo_alarm && !(i_write && i_address == 4'h8) |=> o_servo_alarm;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped without reset");
	property p_db_hold;
		o_dynamic_braking && !i_fault_class1 && !(i_write && i_address == 4'h8) |=> o_dynamic_braking;
	endproperty
	a_db_hold: assert property (p_db_hold) else $error("braking state dropped");
	property p_warn;
		1'b1 |=> o_battery_warning == ($past(i_battery_mv) < 16'h0BB8);
	endproperty
	a_warn: assert property (p_warn) else $error("battery warning wrong");
	property p_bfault;
		i_battery_first_connect |=> o_battery_fault;
	endproperty
	a_bfault: assert property (p_bfault) else $error("battery fault not raised");
	property p_zero_off;
		o_zero_speed_stop && i_motor_stopped && !i_write |-> ##[1:2] !o_motor_power;
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("power kept after zero stop");
	c_db: cover property (o_dynamic_braking);
	c_zero: cover property (o_zero_speed_stop ##1 !o_motor_power);
	c_alarm: cover property (o_servo_alarm && !o_motor_power);
endmodule // pgs_asserts

// ---- tb/tb.sv ----
/* Bench for position_gear_stop: bus tasks, position, gear, battery and fault stops.
   Assumes the motor model as far side and the port checker bound in. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk = 0, i_nrst = 0, i_read = 0, i_write = 0, run = 0, fc = 0, f1 = 0, f2 = 0, pon = 0;
	logic [3:0]  i_address = 4'h0;
	logic [31:0] i_writedata = 32'h0, rd, single = 32'h0;
	logic [15:0] turn = 16'h0, mv = 16'h0FA0;
	logic [15:0] tt[4] = '{16'h0003, 16'h7FFF, 16'h8000, 16'hFFFF};
	logic [31:0] ss[4] = '{32'hFFFFFFFF, 32'h0, 32'h0, 32'h5};
	logic [31:0] cf[3] = '{32'h0, 32'h4, 32'h2};
	logic [63:0] e;
	wire  [31:0] o_readdata, spd;
	wire         o_waitrequest, pwr, db, zs, alarm, bf, bw, irq, stopped, brk;
	int          err_total = 0, comparisons = 0;
	always #25 i_clk = ~i_clk;
	position_gear_stop dut_u (.i_clk, .i_nrst, .i_address, .i_read, .i_write, .i_writedata,
		.i_byteenable(4'hF), .o_readdata, .o_waitrequest, .o_response(), .i_encoder_turn_count(turn),
		.i_single_turn_position(single), .i_battery_first_connect(fc), .i_battery_mv(mv),
		.i_fault_class1(f1), .i_fault_class2(f2), .i_motor_stopped(stopped), .i_motor_speed(spd),
		.i_power_on_seq(pon), .o_motor_power(pwr), .o_dynamic_braking(db), .o_zero_speed_stop(zs),
		.o_brake_release(brk), .o_servo_alarm(alarm), .o_battery_fault(bf), .o_battery_warning(bw), .o_irq(irq));
	motor_model shaft_u (.i_clk, .i_nrst, .i_run(run), .i_power(pwr), .i_brake_stop(db | zs),
		.o_speed(spd), .o_stopped(stopped));
	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= d;
		i_write <= wr;
		i_read <= !wr;
		@(posedge i_clk);
		while (o_waitrequest !== 1'b0 && n < 40) begin
			@(posedge i_clk);
			n++;
		end
		if (n == 40) begin
			err_total++;
			complete_run();
		end
		rd = o_readdata;
		i_write <= 0;
		i_read <= 0;
		@(posedge i_clk);
	endtask
	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] x);
		bus(0, a, 32'h0);
		check(nm, rd, x);
	endtask
	task automatic complete_run();
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		idle(20);
		i_nrst <= 1;
		idle(1);
		for (int k = 0; k < 4; k++) begin
			turn <= tt[k];
			single <= ss[k];
			idle(1);
			e = (64'(tt[k]) - (tt[k][15] ? 64'h10000 : 64'h0)) * 64'h800000 + 64'(ss[k][22:0]);
			rd_chk("single", 4'h7, {9'h0, ss[k][22:0]});
			rd_chk("pos_lo", 4'h4, e[31:0]);
			rd_chk("pos_hi", 4'h5, e[63:32]);
		end
		rd_chk("num", 4'h0, 32'h1);
		rd_chk("den", 4'h1, 32'h1);
		bus(1, 4'h0, 32'h3);
		bus(1, 4'h1, 32'h2);
		bus(1, 4'h2, 32'hA);
		rd_chk("geared", 4'h3, 32'hF);
		run <= 1;
		idle(3);
		bus(1, 4'h0, 32'h5);
		rd_chk("num_run", 4'h0, 32'h3);
		run <= 0;
		idle(20);
		rd_chk("num_stop", 4'h0, 32'h5);
		bus(1, 4'hB, 32'h3);
		fc <= 1;
		idle(1);
		fc <= 0;
		idle(2);
		check("bfault", bf, 1);
		check("irq_on", irq, 1);
		rd_chk("irq_stat", 4'hC, 32'h1);
		idle(1);
		check("irq_off", irq, 0);
		bus(1, 4'h8, 32'h1);
		idle(2);
		check("bfault_clr", bf, 0);
		mv <= 16'h0BB7;
		idle(3);
		check("warn", bw, 1);
		mv <= 16'h0BB8;
		idle(3);
		check("warn_clr", bw, 0);
		bus(1, 4'hB, 32'h0);
		bus(1, 4'hD, 32'h4);
		run <= 1;
		idle(3);
		f1 <= 1;
		idle(3);
		check("c1_pwr", pwr, 0);
		check("c1_alarm", alarm, 1);
		check("irq_mask", irq, 0);
		f1 <= 0;
		idle(4);
		check("alarm_hold", alarm, 1);
		bus(1, 4'h8, 32'h1);
		idle(3);
		check("alarm_clr", alarm, 0);
		for (int k = 0; k < 3; k++) begin
			bus(1, 4'h9, cf[k]);
			idle(3);
			f2 <= 1;
			idle(3);
			check("c2_db", db, cf[k] == 32'h0);
			check("c2_zero", zs, cf[k] != 32'h0);
			idle(25);
			check("c2_pwr", pwr, 0);
			check("c2_db_held", db, cf[k] == 32'h0);
			f2 <= 0;
			bus(1, 4'h8, 32'h1);
			idle(3);
			check("c2_back", pwr, 1);
		end
		bus(1, 4'hF, 32'h4);
		bus(1, 4'h9, 32'h1);
		pon <= 1;
		idle(2);
		check("brk_wait", brk, 0);
		idle(4);
		check("brk_on", brk, 1);
		pon <= 0;
		bus(1, 4'h9, 32'h0);
		pon <= 1;
		idle(2);
		check("brk_free", brk, 1);
		bus(1, 4'hE, 32'h20);
		bus(1, 4'hD, 32'h100);
		bus(1, 4'h9, 32'h2);
		f2 <= 1;
		idle(3);
		check("c2_speed_off", pwr, 0);
		f2 <= 0;
		bus(1, 4'h8, 32'h1);
		idle(3);
		check("c2_speed_back", pwr, 1);
		complete_run();
	end
	initial begin
		idle(20000);
		err_total++;
		complete_run();
	end
endmodule // tb
bind position_gear_stop pgs_asserts chk_u (.i_clk, .i_nrst, .i_address, .i_read, .i_write, .i_battery_mv,
	.i_battery_first_connect, .i_fault_class1, .i_motor_stopped, .o_waitrequest, .o_response, .o_motor_power,
	.o_dynamic_braking, .o_zero_speed_stop, .o_servo_alarm, .o_battery_fault, .o_battery_warning);
